// [src/tap_pkg.sv]
`default_nettype none
package tap_pkg;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } tap_state_t;

  localparam int         IR_LEN      = 4;
  localparam int         BSR_LEN_DEF = 8;
  localparam logic [3:0] IR_EXTEST   = 4'h0;
  localparam logic [3:0] IR_SAMPLE   = 4'h1;
  localparam logic [3:0] IR_BYPASS   = 4'hf;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;
  localparam logic [1:0] SYNC_RESET  = 2'h0;

  // Sixteen-state graph, one step per sampled TMS value.
  function automatic tap_state_t next_state(input tap_state_t s, input logic tms);
    tap_state_t n;
    n = s;
    unique case (s)
      ST_RESET:    n = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     n = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   n = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   n = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   n = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   n = tms ? ST_SEL_DR   : ST_IDLE;
    endcase
    return n;
  endfunction : next_state

endpackage : tap_pkg
`default_nettype wire

// [src/tap_fsm.sv]
`timescale 1ns/10ps
`default_nettype none
module tap_fsm
  import tap_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       tap_rst_in,
  input  wire logic       tck_rise_in,
  input  wire logic       tms_in,
  output var  tap_state_t state_out
);

  tap_state_t state_reg;

  always_ff @(posedge clk_in or posedge tap_rst_in) begin
    if (tap_rst_in) begin
      state_reg <= ST_RESET;
    end else if (tck_rise_in) begin
      // Five high TMS samples reach reset from any state.
      state_reg <= next_state(state_reg, tms_in);
    end
  end

  assign state_out = state_reg;

endmodule : tap_fsm
`default_nettype wire

// [src/bsr_chain.sv]
`timescale 1ns/10ps
`default_nettype none
module bsr_chain #(
  parameter int LEN = 8
) (
  input  wire logic           clk_in,
  input  wire logic           tap_rst_in,
  input  wire logic           capture_in,
  input  wire logic           shift_in,
  input  wire logic           update_in,
  input  wire logic           tdi_in,
  input  wire logic [LEN-1:0] par_in,
  output logic                ser_out,
  output logic      [LEN-1:0] upd_out
);

  logic [LEN-1:0] shift_reg;
  logic [LEN-1:0] upd_reg;

  always_ff @(posedge clk_in or posedge tap_rst_in) begin
    if (tap_rst_in) begin
      shift_reg <= '0;
    end else if (capture_in) begin
      shift_reg <= par_in;
    end else if (shift_in) begin
      shift_reg <= {tdi_in, shift_reg[LEN-1:1]};
    end
  end

  // The latch moves only on update, so pins stay quiet during a shift.
  always_ff @(posedge clk_in or posedge tap_rst_in) begin
    if (tap_rst_in) begin
      upd_reg <= '0;
    end else if (update_in) begin
      upd_reg <= shift_reg;
    end
  end

  assign ser_out = shift_reg[0];
  assign upd_out = upd_reg;

endmodule : bsr_chain
`default_nettype wire

// [src/tap_top.sv]
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Ports TDI, TCK, TMS, TDO, optional TRST.
// - TRST resets the controller asynchronously.
// - All test logic steps on TCK; the code clocks on clk_in and uses sampled TCK edges as enables.
// - Sampled TMS selects the next state.
// - Bypass and boundary-scan registers exist.
// - Bypass is one bit, TDI to TDO.
// - Boundary scan reaches component pins serially.
// - Instruction register, two cells minimum.
// - Synchronous state machine sequences every scan.
// - Five high TMS cycles reach reset.
// - Reset holds while TMS is high.
// - Idle holds while TMS is low.
// - DR select lasts one cycle.
// - IR select lasts one cycle.
// - Capture-DR loads parallel data.
// - Shift-DR shifts one stage per TCK.
// - Pause states hold register contents.
// - Exit2 goes to shift or update.
// - Update-DR loads stable output latch.
// - Capture-IR loads a parallel value.
// - Shift-IR shifts one stage per TCK.
// - Update-IR makes new current instruction.
module tap_top
  import tap_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_DEF
) (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               tck_in,
  input  wire logic               tms_in,
  input  wire logic               tdi_in,
  input  wire logic               trst_n_in,
  input  wire logic [BSR_LEN-1:0] core_pins_in,
  output logic                    tdo_out,
  output logic                    tdo_oe_out,
  output logic      [BSR_LEN-1:0] bsr_pins_out,
  output logic                    extest_out,
  output logic      [IR_LEN-1:0]  instr_out,
  output logic                    tap_reset_out
);

  logic [1:0]        tck_sync_reg;
  logic [1:0]        tms_sync_reg;
  logic [1:0]        tdi_sync_reg;
  logic [1:0]        trst_sync_reg;
  logic              tck_prev_reg;
  logic              tck_rise;
  logic              tck_fall;
  logic              tap_rst;
  tap_state_t        state;
  logic [IR_LEN-1:0] ir_shift_reg;
  logic [IR_LEN-1:0] ir_latch_reg;
  logic              bypass_reg;
  logic              tdo_reg;
  logic              tdo_oe_reg;
  logic              extest_reg;
  logic              bsr_sel;
  logic              bsr_ser;
  logic [BSR_LEN-1:0] bsr_upd;
  logic [BSR_LEN-1:0] bsr_pins_reg;
  logic              tap_reset_reg;

  // Pins from the probe pass two flops; only the second stage is read onward.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tck_sync_reg <= SYNC_RESET;
      tms_sync_reg <= SYNC_RESET;
      tdi_sync_reg <= SYNC_RESET;
      tck_prev_reg <= 1'b0;
    end else begin
      tck_sync_reg <= {tck_sync_reg[0], tck_in};
      tms_sync_reg <= {tms_sync_reg[0], tms_in};
      tdi_sync_reg <= {tdi_sync_reg[0], tdi_in};
      tck_prev_reg <= tck_sync_reg[1];
    end
  end

  // TRST asserts at once and releases through two flops, so the release
  // cannot land mid-edge.
  always_ff @(posedge clk_in or negedge trst_n_in) begin
    if (!trst_n_in) begin
      trst_sync_reg <= SYNC_RESET;
    end else begin
      trst_sync_reg <= {trst_sync_reg[0], 1'b1};
    end
  end

  assign tap_rst  = sys_rst_in | ~trst_sync_reg[1];
  assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
  assign tck_fall = ~tck_sync_reg[1] & tck_prev_reg;

  tap_fsm u_fsm (
    .clk_in      (clk_in),
    .tap_rst_in  (tap_rst),
    .tck_rise_in (tck_rise),
    .tms_in      (tms_sync_reg[1]),
    .state_out   (state)
  );

  // Instruction shift path; pause and exit states fall through and hold.
  always_ff @(posedge clk_in or posedge tap_rst) begin
    if (tap_rst) begin
      ir_shift_reg <= IR_CAPTURE;
    end else if (tck_rise) begin
      if (state == ST_CAP_IR) begin
        ir_shift_reg <= IR_CAPTURE;
      end else if (state == ST_SHIFT_IR) begin
        ir_shift_reg <= {tdi_sync_reg[1], ir_shift_reg[IR_LEN-1:1]};
      end
    end
  end

  // Reset selects bypass so the chip keeps running normally.
  always_ff @(posedge clk_in or posedge tap_rst) begin
    if (tap_rst) begin
      ir_latch_reg <= IR_BYPASS;
    end else if (tck_rise) begin
      if (state == ST_RESET) begin
        ir_latch_reg <= IR_BYPASS;
      end else if (state == ST_UPD_IR) begin
        ir_latch_reg <= ir_shift_reg;
      end
    end
  end

  // Unknown codes fall back to bypass.
  assign bsr_sel = (ir_latch_reg == IR_EXTEST) || (ir_latch_reg == IR_SAMPLE);

  always_ff @(posedge clk_in or posedge tap_rst) begin
    if (tap_rst) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && !bsr_sel) begin
      if (state == ST_CAP_DR) begin
        bypass_reg <= 1'b0;
      end else if (state == ST_SHIFT_DR) begin
        bypass_reg <= tdi_sync_reg[1];
      end
    end
  end

  bsr_chain #(
    .LEN (BSR_LEN)
  ) u_bsr (
    .clk_in     (clk_in),
    .tap_rst_in (tap_rst),
    .capture_in (tck_rise && bsr_sel && state == ST_CAP_DR),
    .shift_in   (tck_rise && bsr_sel && state == ST_SHIFT_DR),
    .update_in  (tck_rise && bsr_sel && state == ST_UPD_DR),
    .tdi_in     (tdi_sync_reg[1]),
    .par_in     (core_pins_in),
    .ser_out    (bsr_ser),
    .upd_out    (bsr_upd)
  );

  // TDO moves on the falling edge so the probe samples a settled bit.
  always_ff @(posedge clk_in or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_reg <= (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
      if (state == ST_SHIFT_IR) begin
        tdo_reg <= ir_shift_reg[0];
      end else if (state == ST_SHIFT_DR) begin
        tdo_reg <= bsr_sel ? bsr_ser : bypass_reg;
      end
    end
  end

  always_ff @(posedge clk_in or posedge tap_rst) begin
    if (tap_rst) begin
      extest_reg    <= 1'b0;
      bsr_pins_reg  <= '0;
      tap_reset_reg <= 1'b1;
    end else begin
      extest_reg    <= (ir_latch_reg == IR_EXTEST) && (state != ST_RESET);
      bsr_pins_reg  <= bsr_upd;
      tap_reset_reg <= (state == ST_RESET);
    end
  end

  assign tdo_out       = tdo_reg;
  assign tdo_oe_out    = tdo_oe_reg;
  assign bsr_pins_out  = bsr_pins_reg;
  assign extest_out    = extest_reg;
  assign instr_out     = ir_latch_reg;
  assign tap_reset_out = tap_reset_reg;

endmodule : tap_top
`default_nettype wire

// [test/tap_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module tap_top_asserts
  import tap_pkg::*;
#(
  parameter int BSR_LEN = 8
) (
  input wire logic               clk_in,
  input wire logic               sys_rst_in,
  input wire logic               tck_in,
  input wire logic               tms_in,
  input wire logic               trst_n_in,
  input wire logic               tdo_out,
  input wire logic               tdo_oe_out,
  input wire logic [BSR_LEN-1:0] bsr_pins_out,
  input wire logic               extest_out,
  input wire logic [IR_LEN-1:0]  instr_out,
  input wire logic               tap_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic       tck_reg;
  logic [2:0] ones_reg;
  logic [3:0] hi_reg;
  // Pin level is watched directly; ones_reg counts at TCK pin rises, hi_reg on every clock.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tck_reg  <= 1'b0;
      ones_reg <= 3'h0;
      hi_reg   <= 4'h0;
    end else begin
      tck_reg <= tck_in;
      hi_reg  <= !tms_in ? 4'h0 : (hi_reg == 4'hf ? hi_reg : hi_reg + 4'h1);
      if (tck_in && !tck_reg) begin
        ones_reg <= !tms_in ? 3'h0 : (ones_reg == 3'h7 ? ones_reg : ones_reg + 3'h1);
      end
    end
  end
  sequence s_trst_held;
    !trst_n_in ##1 !trst_n_in ##1 !trst_n_in;
  endsequence
  AST_TRST_RESET: assert property (s_trst_held |-> tap_reset_out)
    else $error("test reset did not reach reset state");
  AST_TRST_INSTR: assert property (s_trst_held |-> instr_out == IR_BYPASS && !extest_out)
    else $error("test reset left an instruction active");
  AST_FIVE_ONES: assert property (ones_reg == 3'h5 |-> ##[0:8] tap_reset_out)
    else $error("five high mode cycles did not reset");
  AST_STAY_RESET: assert property ($fell(tap_reset_out) |-> hi_reg < 4'hc)
    else $error("reset left while mode stayed high");
  AST_OE_IN_RESET: assert property (tap_reset_out |-> !tdo_oe_out)
    else $error("output driven in reset");
  AST_BSR_STABLE: assert property ($changed(bsr_pins_out) |-> !tdo_oe_out)
    else $error("boundary latch moved during shift");
  AST_INSTR_STABLE: assert property ($changed(instr_out) |-> !tdo_oe_out)
    else $error("instruction moved during shift");
  AST_EXTEST: assert property (extest_out && $stable(instr_out) |-> instr_out == IR_EXTEST)
    else $error("external test flag without its instruction");
  AST_FALL_EDGE: assert property (($changed(tdo_out) || $changed(tdo_oe_out)) && trst_n_in
                                  |-> !tck_in)
    else $error("serial output moved while test clock high");
endmodule : tap_top_asserts
bind tap_top tap_top_asserts #(.BSR_LEN(BSR_LEN)) u_asserts (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck_in), .tms_in(tms_in),
  .trst_n_in(trst_n_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
  .bsr_pins_out(bsr_pins_out), .extest_out(extest_out), .instr_out(instr_out),
  .tap_reset_out(tap_reset_out));
`default_nettype wire

// [test/tap_probe.sv]
`timescale 1ns/10ps
`default_nettype none
module tap_probe (
  input  wire logic clk_in,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in,
  output var  logic tck_out,
  output var  logic tms_out,
  output var  logic tdi_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // One test clock cycle; the clock rests low between steps.
  task automatic step(input logic ms, input logic di, output logic so);
    @(posedge clk_in);
    #1 tms_out = ms;
    tdi_out = di;
    repeat (5) @(posedge clk_in);
    #1 tck_out = 1'b1;
    so = tdo_oe_in ? tdo_in : 1'b1; // A pull-up holds a released line high.
    repeat (5) @(posedge clk_in);
    #1 tck_out = 1'b0;
  endtask : step
endmodule : tap_probe
`default_nettype wire

// [test/tb_tap_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_tap_top;
  import tap_pkg::*;
  logic            clk_in = 1'b0;
  logic            sys_rst_in = 1'b1;
  logic            trst_n_in = 1'b1;
  logic [7:0]      core_pins_in = 8'ha5;
  wire logic       tck, tms, tdi, tdo, tdo_oe, extest, tap_rst;
  wire logic [7:0] bsr_pins;
  wire logic [3:0] instr;
  int              n_mismatch = 0;
  int              checks_done = 0;
  int              cyc = 0;
  always #4 clk_in = ~clk_in;
  tap_probe probe (.clk_in(clk_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck),
                   .tms_out(tms), .tdi_out(tdi));
  tap_top #(.BSR_LEN(8)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck),
    .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n_in), .core_pins_in(core_pins_in),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .bsr_pins_out(bsr_pins), .extest_out(extest),
    .instr_out(instr), .tap_reset_out(tap_rst));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tms_seq(input logic [7:0] bits, input int n);
    logic d;
    for (int i = 0; i < n; i++) begin
      probe.step(bits[i], 1'b0, d);
    end
    repeat (6) @(posedge clk_in);
  endtask : tms_seq
  // Scan from idle, LSB first, with an optional pause after bit pz.
  task automatic scan(input logic ir, input int n, input int pz, input logic [7:0] din,
                      output logic [7:0] dout);
    logic d;
    dout = 8'h00;
    tms_seq(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      probe.step(i == n - 1 || i == pz, din[i], d);
      dout[i] = d;
      if (i == pz && i != n - 1) begin
        tms_seq(8'h04, 4);
      end
    end
    tms_seq(8'h01, 2);
  endtask : scan
  task automatic t_ir(input logic [3:0] code);
    logic [7:0] q;
    scan(1'b1, 4, 1, 8'(code), q);
    check(q, 8'(IR_CAPTURE));
    check(8'(instr), 8'(code));
    check(8'(extest), 8'(code == IR_EXTEST));
  endtask : t_ir
  task automatic t_bypass;
    logic [7:0] q;
    t_ir(IR_BYPASS);
    scan(1'b0, 8, 99, 8'h5b, q);
    check(q, 8'hb6);
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_bsr;
    logic [7:0] q;
    t_ir(IR_SAMPLE);
    scan(1'b0, 8, 3, 8'h3c, q);
    check(q, 8'ha5);
    check(bsr_pins, 8'h3c);
    $display("test boundary done");
  endtask : t_bsr
  task automatic t_trst;
    t_ir(IR_EXTEST);
    @(posedge clk_in);
    #1 trst_n_in = 1'b0;
    repeat (5) @(posedge clk_in);
    check(8'({tap_rst, extest, instr}), 8'h2f);
    #1 trst_n_in = 1'b1;
    $display("test trst done");
  endtask : t_trst
  task automatic t_five;
    tms_seq(8'h00, 1);
    check(8'(tap_rst), 8'h00);
    tms_seq(8'h01, 3);
    tms_seq(8'h0f, 4);
    check(8'(tap_rst), 8'h00);
    tms_seq(8'h01, 1);
    check(8'(tap_rst), 8'h01);
    tms_seq(8'h07, 3);
    check(8'(tap_rst), 8'h01);
    tms_seq(8'h00, 4);
    check(8'(tap_rst), 8'h00);
    $display("test five done");
  endtask : t_five
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // The whole run takes about 1100 cycles, so this ceiling leaves ample slack.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    repeat (6) @(posedge clk_in);
    check(8'({tap_rst, extest, instr}), 8'h2f);
    tms_seq(8'h00, 1);
    t_bypass;
    t_bsr;
    t_trst;
    t_five;
    tally_and_finish;
  end
endmodule : tb_tap_top
`default_nettype wire
